// *** include/fault_pkg.sv ***
// constants and state type for the fault latch status monitor
package fault_pkg;
	// number of nonvolatile trim bits covered by parity
	localparam int TRIM_BITS = 16;
	// sync stages for pin inputs
	localparam int SYNC_STAGES = 2;
	// reset values
	localparam logic LATCH_RESET = 1'b0;
	localparam logic SAMPLE_RESET = 1'b0;
	localparam logic SEEN_EDGE_RESET = 1'b0;

	typedef enum logic [0:0] {
		ST_UNARMED,
		ST_ARMED
	} valid_state_t;
endpackage : fault_pkg

// *** include/fault_if.sv ***
// fault condition bundle from the synchroniser to the latch logic
`timescale 1ns/1ns
`default_nettype none
interface fault_if;
	logic low_supply;
	logic clock_slow;
	logic parity_odd;
	logic self_test;
	modport src (
		output low_supply,
		output clock_slow,
		output parity_odd,
		output self_test
	);
	modport dst (
		input low_supply,
		input clock_slow,
		input parity_odd,
		input self_test
	);
endinterface : fault_if
`default_nettype wire

// *** core/fault_sync.sv ***
// two-stage synchroniser for monitor flags, trim parity and the self-test pin
`timescale 1ns/1ns
`default_nettype none
module fault_sync (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic low_supply_detect,
	input wire logic clock_monitor_fail,
	input wire logic [fault_pkg::TRIM_BITS-1:0] trim_bits,
	input wire logic self_test_input,
	fault_if.src flags
);
	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;
	logic parity_raw;

	assign parity_raw = ^trim_bits;

	always_comb begin
		s_d = s_q;
		s_d.meta = {self_test_input, parity_raw, clock_monitor_fail, low_supply_detect};
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags.low_supply = s_q.sync[0];
	assign flags.clock_slow = s_q.sync[1];
	assign flags.parity_odd = s_q.sync[2];
	assign flags.self_test = s_q.sync[3];
endmodule : fault_sync
`default_nettype wire

// *** core/fault_latch_status_monitor.sv ***
// fault latch and status output driven by supply, clock and trim parity monitors
//
// How it works
// - Status output equals fault latch OR current self-test level.
// - Low supply detect sets the fault latch.
// - Oscillator below minimum frequency sets the fault latch.
// - Odd parity over trim bits sets the fault latch.
// - Self-test rising edge clears latch only when no fault is active.
// - Self-test excitation held active while the self-test input is high.
// - Status invalid after power-up until first self-test rising edge.
//
// latency: a pin change shows on the outputs at the third clock edge,
// two edges of synchroniser and one of state.
// limitation: a fault or self-test pulse shorter than one clock may be missed.
// all outputs leave flip-flops, so the host never sees a glitch on status.
`timescale 1ns/1ns
`default_nettype none
module fault_latch_status_monitor (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic self_test_input,
	input wire logic low_supply_detect,
	input wire logic clock_monitor_fail,
	input wire logic [fault_pkg::TRIM_BITS-1:0] trim_bits,
	output logic status,
	output logic status_valid,
	output logic self_test_drive
);
	// =====================================================
	// synchronised inputs
	fault_if flags ();

	fault_sync u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.low_supply_detect(low_supply_detect),
		.clock_monitor_fail(clock_monitor_fail),
		.trim_bits(trim_bits),
		.self_test_input(self_test_input),
		.flags(flags.src)
	);

	// =====================================================
	// local copies of the synchronised flags
	logic low_supply_s;
	logic clock_slow_s;
	logic parity_odd_s;
	logic self_test_s;

	assign low_supply_s = flags.low_supply;
	assign clock_slow_s = flags.clock_slow;
	assign parity_odd_s = flags.parity_odd;
	assign self_test_s = flags.self_test;

	// =====================================================
	// helper functions
	// any monitor reporting a fault
	function automatic logic fault_any(
		input logic low_supply,
		input logic clock_slow,
		input logic parity_odd
	);
		// a fault is a level, so it keeps the latch set while it lasts
		fault_any = low_supply | clock_slow | parity_odd;
	endfunction : fault_any

	function automatic logic rise_of(
		input logic now_level,
		input logic last_level
	);
		// previous sample resets low, the idle level of the pin
		rise_of = now_level & ~last_level;
	endfunction : rise_of

	function automatic logic latch_next(
		input logic latch_now,
		input logic fault,
		input logic rise
	);
		logic nxt;
		nxt = latch_now;
		// set wins, so a clear never hides a fault seen in the same cycle
		if (fault) begin
			nxt = 1'b1;
		end else if (rise) begin
			nxt = 1'b0;
		end
		latch_next = nxt;
	endfunction : latch_next

	// arming by the first rising edge
	function automatic fault_pkg::valid_state_t valid_next(
		input fault_pkg::valid_state_t valid_now,
		input logic rise
	);
		fault_pkg::valid_state_t nxt;
		nxt = valid_now;
		case (valid_now)
			fault_pkg::ST_UNARMED: begin
				if (rise) begin
					nxt = fault_pkg::ST_ARMED;
				end
			end
			default: begin
				nxt = fault_pkg::ST_ARMED;
			end
		endcase
		valid_next = nxt;
	endfunction : valid_next

	function automatic logic status_of(
		input logic latch_level,
		input logic test_level
	);
		status_of = latch_level | test_level;
	endfunction : status_of

	function automatic logic drive_of(
		input logic test_level
	);
		drive_of = test_level;
	endfunction : drive_of

	function automatic logic armed_of(
		input fault_pkg::valid_state_t valid_now
	);
		armed_of = (valid_now == fault_pkg::ST_ARMED);
	endfunction : armed_of

	// =====================================================
	// state
	typedef struct packed {
		// fault latch itself
		logic latch;
		// last synchronised self-test sample
		logic st_prev;
		// unarmed until the first self-test rise
		fault_pkg::valid_state_t valid;
		// registered status pin value
		logic status;
		// registered excitation enable
		logic drive;
	} mon_state_t;

	mon_state_t s_q;
	mon_state_t s_d;
	logic fault_now;
	logic st_rise;

	always_comb begin
		s_d = s_q;

		fault_now = fault_any(
			low_supply_s,
			clock_slow_s,
			parity_odd_s
		);

		st_rise = rise_of(
			self_test_s,
			s_q.st_prev
		);
		s_d.st_prev = self_test_s;

		// set wins, clear only without fault
		s_d.latch = latch_next(
			s_q.latch,
			fault_now,
			st_rise
		);

		s_d.valid = valid_next(
			s_q.valid,
			st_rise
		);

		// new latch value used, so status rises with the latch
		s_d.status = status_of(
			s_d.latch,
			self_test_s
		);

		s_d.drive = drive_of(
			self_test_s
		);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_q.latch <= fault_pkg::LATCH_RESET;
			s_q.st_prev <= fault_pkg::SAMPLE_RESET;
			s_q.valid <= fault_pkg::ST_UNARMED;
			s_q.status <= fault_pkg::LATCH_RESET;
			s_q.drive <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// =====================================================
	// outputs, all registered
	// fault latch or self-test
	assign status = s_q.status;

	// host must ignore status while this is low
	assign status_valid = armed_of(s_q.valid);

	assign self_test_drive = s_q.drive;
endmodule : fault_latch_status_monitor
`default_nettype wire

// *** verification/host_model.sv ***
// host side: drives the self-test pin
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic core_clk,
	input wire logic want,
	output var logic self_test_input = 1'b0
);
// raise pin to test and arm
always @(negedge core_clk) self_test_input <= want;
endmodule : host_model
`default_nettype wire

// *** verification/fault_mon_sva.sv ***
// port assertions for the fault monitor
`timescale 1ns/1ns
`default_nettype none
module fault_mon_sva (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic self_test_input,
	input wire logic low_supply_detect,
	input wire logic clock_monitor_fail,
	input wire logic status,
	input wire logic status_valid,
	input wire logic self_test_drive,
	input wire logic [fault_pkg::TRIM_BITS-1:0] trim_bits
);
default clocking @(posedge core_clk); endclocking
default disable iff (srst);
AST_OR: assert property (self_test_drive |-> status) else $error("or");
AST_LOW: assert property (low_supply_detect |-> ##[1:5] status) else $error("low");
AST_CLK: assert property (clock_monitor_fail |-> ##[1:5] status) else $error("clk");
AST_PAR: assert property (^trim_bits |-> ##[1:5] status) else $error("par");
AST_HOLD: assert property (low_supply_detect [*6] |-> status) else $error("hold");
AST_DRV: assert property (self_test_input [*5] |-> self_test_drive) else $error("drv");
AST_ARM: assert property ($rose(status_valid) |-> self_test_drive) else $error("arm");
AST_KEEP: assert property (status_valid |=> status_valid) else $error("keep");
AST_SYN: assert property (!self_test_input [*5] |-> !self_test_drive) else $error("syn");
cover property ($rose(status_valid));
cover property ($fell(status));
cover property (status && !status_valid);
endmodule : fault_mon_sva
bind fault_latch_status_monitor fault_mon_sva SVA (.*);
`default_nettype wire

// *** verification/fault_latch_status_monitor_tb.sv ***
// self-checking bench for the fault monitor
`timescale 1ns/1ns
`default_nettype none
module fault_latch_status_monitor_tb;
logic core_clk=0, srst=1, want=0, e=0, self_test_input, status, status_valid, self_test_drive;
logic low_supply_detect=0, clock_monitor_fail=0;
logic [15:0] trim_bits=16'h0;
logic [31:0] r=32'hB222;
int num_errors, n_tests;
initial forever #25 core_clk = ~core_clk;
host_model HOST (
	.core_clk(core_clk),
	.want(want),
	.self_test_input(self_test_input)
);
fault_latch_status_monitor DUT (
	.core_clk(core_clk),
	.srst(srst),
	.self_test_input(self_test_input),
	.low_supply_detect(low_supply_detect),
	.clock_monitor_fail(clock_monitor_fail),
	.trim_bits(trim_bits),
	.status(status),
	.status_valid(status_valid),
	.self_test_drive(self_test_drive)
);
function logic [31:0] xs(input logic [31:0] v);
	logic [31:0] t;
	t = v ^ (v << 13);
	t = t ^ (t >> 17);
	xs = t ^ (t << 5);
endfunction : xs
function logic f();
	return ^trim_bits | low_supply_detect | clock_monitor_fail;
endfunction : f
task chk(input logic g, x);
	n_tests++;
	if (g !== x) begin
		num_errors++;
		$display("[FAIL] %0t %h %h", $time, g, x);
	end
endtask : chk
task w;
	repeat (6) @(negedge core_clk);
endtask : w
task stop_test;
	$display("errors %0d tests %0d", num_errors, n_tests);
	if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask : stop_test
initial begin
	repeat (20) @(negedge core_clk);
	srst = 0;
	w;
	chk(status_valid, 1'b0);
	for (int i = 0; i < 16; i++) begin
		r = xs(r);
		{clock_monitor_fail, low_supply_detect, trim_bits} = (i == 0) ? 18'h00001 :
			(i == 1) ? 18'h00000 : r[17:0];
		w;
		chk(status, e | f());
		want = 1;
		w;
		chk(status & status_valid & self_test_drive, 1'b1);
		want = 0;
		w;
		e = f();
		chk(status, e);
		chk(self_test_drive, 1'b0);
	end
	stop_test;
end
endmodule : fault_latch_status_monitor_tb
`default_nettype wire
